// ==== rtl/uart_rx_pkg.sv ====
// Purpose: constants shared by the serial receiver block
// Assumes: AHB-Lite word access, one 20 MHz clock
// Notes: offsets are byte addresses
package uart_rx_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CTRL_ONE = 8'h04;
	localparam logic [7:0] OFS_CTRL_TWO = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0C;
	localparam logic [7:0] OFS_BAUD = 8'h10;
	// serial_status_reg fields
	localparam int ST_RXAV = 0;
	localparam int ST_OVR = 1;
	localparam int ST_NOISE = 2;
	localparam int ST_FRAME = 3;
	localparam int ST_PARITY = 4;
	localparam int ST_RXIDLE = 5;
	localparam int ST_TXEMPTY = 6;
	localparam int ST_TXIDLE = 7;
	// serial_ctrl_one fields
	localparam int C1_NINE = 0;
	localparam int C1_PTYPE = 1;
	localparam int C1_PEN = 2;
	localparam int C1_RX9 = 3;
	// serial_ctrl_two fields
	localparam int C2_RXEN = 0;
	localparam int C2_RIE = 1;
	localparam int C2_ADDEN = 2;
	localparam int C2_WAKE = 3;
	localparam int C2_TEIE = 4;
	localparam int C2_TIIE = 5;
	// Reset values
	localparam logic [2:0] CTRL_ONE_RST = 3'h0;
	localparam logic [5:0] CTRL_TWO_RST = 6'h00;
	localparam logic [15:0] BAUD_RST = 16'h0000;
	// Oversampling: 16 ticks a bit, votes at ticks 7, 8 and 9
	localparam int OS_RATE = 16;
	localparam logic [3:0] OS_SAMP_A = 4'h7;
	localparam logic [3:0] OS_SAMP_B = 4'h8;
	localparam logic [3:0] OS_VOTE = 4'h9;
	localparam logic [3:0] BITS_NINE = 4'h9;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;
	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA = 5'b00100,
		RX_STOP = 5'b01000,
		RX_BREAK = 5'b10000
	} rx_state_e;
endpackage

// ==== rtl/uart_rx_core.sv ====
// Purpose: receive half of a serial port with error flags and interrupt combine
// Assumes: inputs synchronous to MCLK, AHB-Lite single word transfers
// Notes: zero wait states, response always OKAY
//
// Functional notes
// - RX bits are shifted in one at a time, least significant first.
// - Receive buffer holds two finished words while a third assembles.
// - Third word with full buffer sets overrun, is dropped, buffer kept.
// - Overrun requests an interrupt when receive interrupt enable is set.
// - Setting receiver enable starts the search for a start bit.
// - Data-available flag is set whenever the buffer holds a word.
// - Data-available clears when a data read takes the last word from the buffer.
// - Each word moved into the buffer requests an interrupt if enabled.
// - Break is a framing error word of zeros, sets available and idle.
// - After a break, wait for high line before seeking a start bit.
// - Idle flag low from start detect to stop sample or to a high start-bit vote, high otherwise.
// - Noise sets its flag with the word load, no own interrupt.
// - Noise flag clears through status read then data read.
// - Framing error when stop bit samples low; cleared when its word is read out.
// - Parity error when enabled parity mismatches selected type.
// - Five conditions combine into one low-pulse interrupt request.
// - Tx conditions have own enables; all three rx conditions share one.
// - Address detect requests interrupt without a status flag.
// - With clock stopped, wake, rx enable and receive interrupt enable, RX fall interrupts.
// - Status flags are read-only; only hardware sequences change them.
// - Overrun clears through status read then data read.
// - Sixteen-times oversampling, each level is a three-sample vote.
// - Receiver checks a single stop bit only.
// - In nine-bit mode the top bit shows in control register one.
// - In address mode, load interrupt only when the top bit is high.
`timescale 1ns/100ps
module uart_rx_core (
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Serial line and transmitter conditions
	input wire logic RX_IN,
	input wire logic TX_EMPTY_IN,
	input wire logic TX_IDLE_IN,
	input wire logic CLK_STOPPED,
	// Module interrupt request
	output logic IRQ_N
);

	function automatic logic vote3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (SYS_RST);

	////////////////////////////////////////////////////////////////////////
	// Register bus
	logic [2:0] ctrl_one_r;
	logic [5:0] ctrl_two_r;
	logic [15:0] baud_divider_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic status_seen_r;
	logic bus_go;
	logic rd_data;
	logic rd_status;
	logic clear_ok;
	logic [31:0] rd_mux;

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign bus_go = HSEL & HTRANS[1] & HREADY;
	assign rd_data = bus_go & !HWRITE & (HADDR[7:0] == uart_rx_pkg::OFS_DATA);
	assign rd_status = bus_go & !HWRITE & (HADDR[7:0] == uart_rx_pkg::OFS_STATUS);
	assign clear_ok = rd_data & status_seen_r;

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end
		else
		begin
			wr_pend_r <= bus_go & HWRITE;
			wr_addr_r <= HADDR[7:0];
		end
	end

	// Status bits have no write path at all
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			ctrl_one_r <= uart_rx_pkg::CTRL_ONE_RST;
			ctrl_two_r <= uart_rx_pkg::CTRL_TWO_RST;
			baud_divider_r <= uart_rx_pkg::BAUD_RST;
		end
		else if (wr_pend_r)
		begin
			if (wr_addr_r == uart_rx_pkg::OFS_CTRL_ONE)
				ctrl_one_r <= HWDATA[2:0];
			if (wr_addr_r == uart_rx_pkg::OFS_CTRL_TWO)
				ctrl_two_r <= HWDATA[5:0];
			if (wr_addr_r == uart_rx_pkg::OFS_BAUD)
				baud_divider_r <= HWDATA[15:0];
		end
	end

	// A status read arms the clear; the data read that follows uses it
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			status_seen_r <= 1'b0;
		else if (rd_status)
			status_seen_r <= 1'b1;
		else if (rd_data)
			status_seen_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Control fields
	logic nine_bit_select;
	logic parity_type_select;
	logic parity_enable;
	logic receiver_enable;
	logic rx_irq_enable;
	logic address_detect_enable;
	logic rx_wake_enable;

	assign nine_bit_select = ctrl_one_r[uart_rx_pkg::C1_NINE];
	assign parity_type_select = ctrl_one_r[uart_rx_pkg::C1_PTYPE];
	assign parity_enable = ctrl_one_r[uart_rx_pkg::C1_PEN];
	assign receiver_enable = ctrl_two_r[uart_rx_pkg::C2_RXEN];
	assign rx_irq_enable = ctrl_two_r[uart_rx_pkg::C2_RIE];
	assign address_detect_enable = ctrl_two_r[uart_rx_pkg::C2_ADDEN];
	assign rx_wake_enable = ctrl_two_r[uart_rx_pkg::C2_WAKE];

	////////////////////////////////////////////////////////////////////////
	// Oversampling tick, paused while the serial clock is stopped
	logic [15:0] div_cnt_r;
	logic os_tick;

	assign os_tick = receiver_enable & !CLK_STOPPED & (div_cnt_r == baud_divider_r);

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST | !receiver_enable | os_tick)
			div_cnt_r <= 16'h0000;
		else if (!CLK_STOPPED)
			div_cnt_r <= div_cnt_r + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver sequence
	uart_rx_pkg::rx_state_e state_r;
	logic [3:0] os_cnt_r;
	logic [3:0] bit_cnt_r;
	logic [8:0] rx_shift_reg_r;
	logic [1:0] samp_r;
	logic noise_acc_r;
	logic rx_idle_flag_r;
	logic decide;
	logic level;
	logic disagree;
	logic start_seen;
	logic word_done;
	logic [3:0] frame_bits;

	assign decide = os_tick & (os_cnt_r == uart_rx_pkg::OS_VOTE);
	assign level = vote3(samp_r[1], samp_r[0], RX_IN);
	assign disagree = !((samp_r[1] == samp_r[0]) & (samp_r[0] == RX_IN));
	assign start_seen = (state_r == uart_rx_pkg::RX_IDLE) & os_tick & !RX_IN;
	assign word_done = decide & (state_r == uart_rx_pkg::RX_STOP);
	assign frame_bits = nine_bit_select ? uart_rx_pkg::BITS_NINE : uart_rx_pkg::BITS_EIGHT;

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			os_cnt_r <= 4'h0;
		else if (start_seen)
			os_cnt_r <= 4'h1;
		else if (os_tick)
			os_cnt_r <= os_cnt_r + 4'h1;
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			samp_r <= 2'h0;
		else if (os_tick & (os_cnt_r == uart_rx_pkg::OS_SAMP_A))
			samp_r[1] <= RX_IN;
		else if (os_tick & (os_cnt_r == uart_rx_pkg::OS_SAMP_B))
			samp_r[0] <= RX_IN;
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST | !receiver_enable)
			state_r <= uart_rx_pkg::RX_IDLE;
		else
		begin
			unique case (state_r)
				uart_rx_pkg::RX_IDLE:
					if (start_seen)
						state_r <= uart_rx_pkg::RX_START;
				uart_rx_pkg::RX_START:
					if (decide)
						state_r <= level ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA;
				uart_rx_pkg::RX_DATA:
					if (decide & (bit_cnt_r == frame_bits - 4'h1))
						state_r <= uart_rx_pkg::RX_STOP;
				uart_rx_pkg::RX_STOP:
					if (decide)
						state_r <= level ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_BREAK;
				uart_rx_pkg::RX_BREAK:
					if (os_tick & RX_IN)
						state_r <= uart_rx_pkg::RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			bit_cnt_r <= 4'h0;
			rx_shift_reg_r <= 9'h000;
		end
		else if (state_r == uart_rx_pkg::RX_START)
		begin
			bit_cnt_r <= 4'h0;
			rx_shift_reg_r <= 9'h000;
		end
		else if (decide & (state_r == uart_rx_pkg::RX_DATA))
		begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
			rx_shift_reg_r <= {level, rx_shift_reg_r[8:1]};
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST | start_seen)
			noise_acc_r <= 1'b0;
		else if (decide & disagree)
			noise_acc_r <= 1'b1;
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			rx_idle_flag_r <= 1'b1;
		else if (start_seen & receiver_enable)
			rx_idle_flag_r <= 1'b0;
		else if (word_done | (decide & (state_r == uart_rx_pkg::RX_START) & level))
			rx_idle_flag_r <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Finished word and its error bits
	logic [8:0] rx_word;
	logic word_fe;
	logic word_pe;
	logic word_nz;
	logic word_msb;

	assign rx_word = nine_bit_select ? rx_shift_reg_r : {1'b0, rx_shift_reg_r[8:1]};
	assign word_fe = !level;
	assign word_pe = parity_enable & ((^rx_word) != parity_type_select);
	assign word_nz = noise_acc_r | disagree;
	assign word_msb = nine_bit_select ? rx_word[8] : rx_word[7];

	////////////////////////////////////////////////////////////////////////
	// Two-entry receive buffer
	logic [10:0] buf_r [0:1];
	logic rd_ptr_r;
	logic [1:0] count_r;
	logic push;
	logic pop;
	logic overrun_evt;
	logic wr_idx;
	logic [10:0] head;
	logic rx_data_available;

	assign push = word_done & (count_r != uart_rx_pkg::FIFO_DEPTH);
	assign overrun_evt = word_done & (count_r == uart_rx_pkg::FIFO_DEPTH);
	assign pop = rd_data & (count_r != 2'h0);
	assign wr_idx = rd_ptr_r ^ count_r[0];
	assign head = buf_r[rd_ptr_r];
	assign rx_data_available = (count_r != 2'h0);

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			buf_r[0] <= 11'h000;
			buf_r[1] <= 11'h000;
		end
		else if (push)
			buf_r[wr_idx] <= {word_pe, word_fe, rx_word};
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
		end
		else
		begin
			if (pop)
				rd_ptr_r <= !rd_ptr_r;
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky overrun and noise; a new event beats a clear
	logic overrun_flag_r;
	logic noise_flag_r;

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			overrun_flag_r <= 1'b0;
		else
			overrun_flag_r <= overrun_evt | (overrun_flag_r & !clear_ok);
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			noise_flag_r <= 1'b0;
		else
			noise_flag_r <= (push & word_nz) | (noise_flag_r & !clear_ok);
	end

	////////////////////////////////////////////////////////////////////////
	// Read data
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (HADDR[7:0])
			uart_rx_pkg::OFS_STATUS:
			begin
				rd_mux[uart_rx_pkg::ST_RXAV] = rx_data_available;
				rd_mux[uart_rx_pkg::ST_OVR] = overrun_flag_r;
				rd_mux[uart_rx_pkg::ST_NOISE] = noise_flag_r;
				rd_mux[uart_rx_pkg::ST_FRAME] = rx_data_available & head[9];
				rd_mux[uart_rx_pkg::ST_PARITY] = rx_data_available & head[10];
				rd_mux[uart_rx_pkg::ST_RXIDLE] = rx_idle_flag_r;
				rd_mux[uart_rx_pkg::ST_TXEMPTY] = TX_EMPTY_IN;
				rd_mux[uart_rx_pkg::ST_TXIDLE] = TX_IDLE_IN;
			end
			uart_rx_pkg::OFS_CTRL_ONE:
			begin
				rd_mux[2:0] = ctrl_one_r;
				rd_mux[uart_rx_pkg::C1_RX9] = rx_data_available & nine_bit_select & head[8];
			end
			uart_rx_pkg::OFS_CTRL_TWO:
				rd_mux[5:0] = ctrl_two_r;
			uart_rx_pkg::OFS_DATA:
				rd_mux[8:0] = rx_data_available ? head[8:0] : 9'h000;
			uart_rx_pkg::OFS_BAUD:
				rd_mux[15:0] = baud_divider_r;
			default:
				rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			HRDATA <= 32'h0000_0000;
		else if (bus_go & !HWRITE)
			HRDATA <= rd_mux;
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt combine
	logic rx_prev_r;
	logic tx_prev_r;
	logic irq_n_r;
	logic tx_req;
	logic load_irq;
	logic ovr_irq;
	logic wake_irq;
	logic any_irq;

	assign tx_req = (TX_EMPTY_IN & ctrl_two_r[uart_rx_pkg::C2_TEIE]) |
		(TX_IDLE_IN & ctrl_two_r[uart_rx_pkg::C2_TIIE]);
	assign load_irq = push & rx_irq_enable & (!address_detect_enable | word_msb);
	assign ovr_irq = overrun_evt & rx_irq_enable;
	assign wake_irq = CLK_STOPPED & rx_wake_enable & rx_irq_enable & receiver_enable &
		rx_prev_r & !RX_IN;
	assign any_irq = load_irq | ovr_irq | wake_irq | (tx_req & !tx_prev_r);
	assign IRQ_N = irq_n_r;

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			rx_prev_r <= 1'b1;
			tx_prev_r <= 1'b0;
			irq_n_r <= 1'b1;
		end
		else
		begin
			rx_prev_r <= RX_IN;
			tx_prev_r <= tx_req;
			irq_n_r <= !any_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_overrun_keeps_buf: assert property (overrun_evt |=> overrun_flag_r && count_r == 2'h2)
		else $error("overrun lost buffer or flag");
	a_push_grows: assert property (push && !pop |=> count_r == $past(count_r) + 2'h1)
		else $error("buffer did not take word");
	a_pop_advances: assert property (pop && !push |=> count_r == $past(count_r) - 2'h1)
		else $error("data read did not advance");
	a_load_irq_pulse: assert property (load_irq |=> !IRQ_N ##1 (IRQ_N || $past(any_irq)))
		else $error("load interrupt pulse wrong");
	a_ovr_irq: assert property (overrun_evt && rx_irq_enable |=> !IRQ_N)
		else $error("overrun gave no interrupt");
	a_idle_at_stop: assert property (word_done |=> rx_idle_flag_r)
		else $error("idle not set at stop");
	a_start_clears_idle: assert property (start_seen && receiver_enable |=>
		!rx_idle_flag_r && state_r == uart_rx_pkg::RX_START)
		else $error("start not detected");
	a_break_holds: assert property (state_r == uart_rx_pkg::RX_BREAK && !RX_IN && receiver_enable
		|=> state_r == uart_rx_pkg::RX_BREAK)
		else $error("low line taken as start");
	a_noise_with_load: assert property (push && word_nz |=> noise_flag_r && rx_data_available)
		else $error("noise flag not set with word");
	a_frame_on_empty: assert property (push && count_r == 2'h0 && !pop && !level
		|=> head[9] && head[8:0] == $past(rx_word))
		else $error("framing error not recorded");
	a_ovr_sticky: assert property (overrun_flag_r && !clear_ok |=> overrun_flag_r)
		else $error("overrun cleared without sequence");
endmodule

// ==== sim/serial_tx_model.sv ====
// Purpose: remote serial transmitter that drives the receive line
// Assumes: baud divider 0, so one bit lasts BIT_CYC clock cycles
// Notes: the line idles high; a glitch flips one cycle in mid-bit
`timescale 1ns/100ps
module serial_tx_model #(
	parameter int BIT_CYC = 16
) (
	// Clock
	input wire logic clk,
	// Serial line
	output logic line
);
	initial line = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Holds a level for n cycles, changed just after an edge
	task automatic hold(input logic lvl, input int n);
		line <= lvl;
		repeat (n) @(posedge clk);
	endtask

	// Start bit, n bits LSB first, stop level for nstp bit times, then idle
	task automatic send(input logic [8:0] d, input int n, input logic stp, input int nstp,
		input int glitch);
		int i;
		@(posedge clk);
		hold(1'b0, BIT_CYC);
		for (i = 0; i < n; i++)
		begin
			if (i == glitch)
			begin
				hold(d[i], BIT_CYC / 2);
				hold(~d[i], 1);
				hold(d[i], BIT_CYC / 2 - 1);
			end
			else
				hold(d[i], BIT_CYC);
		end
		hold(stp, BIT_CYC * nstp);
		hold(1'b1, 2 * BIT_CYC);
	endtask
endmodule

// ==== sim/test_uart_rx_core.sv ====
// Purpose: self-checking bench for the serial receiver block
// Assumes: zero wait state bus slave, baud divider 0
// Notes: interrupt pulses are counted and compared as deltas
`timescale 1ns/100ps
module test_uart_rx_core;
	localparam logic [7:0] A_ST = uart_rx_pkg::OFS_STATUS;
	localparam logic [7:0] A_C1 = uart_rx_pkg::OFS_CTRL_ONE;
	localparam logic [7:0] A_C2 = uart_rx_pkg::OFS_CTRL_TWO;
	localparam logic [7:0] A_DAT = uart_rx_pkg::OFS_DATA;
	localparam logic [7:0] A_BAUD = uart_rx_pkg::OFS_BAUD;
	logic MCLK, SYS_RST, HSEL, HWRITE, HREADYOUT, HRESP, RX_IN, IRQ_N;
	logic TX_EMPTY_IN, TX_IDLE_IN, CLK_STOPPED;
	logic [31:0] HADDR, HWDATA, HRDATA, v, irq_cnt, irq_base;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	int err_count = 0;
	int checked = 0;
	int i;
	logic [31:0] par_c [4] = '{32'h6, 32'h6, 32'h4, 32'h4};
	logic [8:0] par_d [4] = '{9'h001, 9'h081, 9'h001, 9'h003};
	logic [31:0] par_s [4] = '{32'h21, 32'h31, 32'h31, 32'h21};
	logic [31:0] ad_c [3] = '{32'h7, 32'h7, 32'h1};
	logic [8:0] ad_d [3] = '{9'h012, 9'h092, 9'h092};
	logic [31:0] ad_n [3] = '{32'h0, 32'h1, 32'h0};

	uart_rx_core u_dut (
		.MCLK(MCLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_IN(RX_IN),
		.TX_EMPTY_IN(TX_EMPTY_IN), .TX_IDLE_IN(TX_IDLE_IN), .CLK_STOPPED(CLK_STOPPED),
		.IRQ_N(IRQ_N)
	);
	serial_tx_model #(.BIT_CYC(16)) u_tx (.clk(MCLK), .line(RX_IN));

	initial
	begin
		MCLK = 1'b0;
		forever #25 MCLK = ~MCLK;
	end

	// Counts cycles with the interrupt request low
	always @(posedge MCLK)
	begin
		if (SYS_RST)
			irq_cnt <= 32'h0;
		else if (IRQ_N === 1'b0)
			irq_cnt <= irq_cnt + 32'h1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One single word transfer: address phase, then data phase
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge MCLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {24'h000000, a};
		HWRITE <= wr;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(a, 1'b1, d, dummy);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] got;
		bus(a, 1'b0, 32'h0, got);
		chk(got, e);
	endtask

	// Interrupt count since last mark, then status and the popped word
	task automatic expect_word(input logic [31:0] st, input logic [31:0] dat,
		input logic [31:0] irqs);
		chk(irq_cnt - irq_base, irqs);
		rdc(A_ST, st);
		rdc(A_DAT, dat);
		irq_base = irq_cnt;
	endtask

	task automatic complete_run();
		if (err_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge MCLK);
		err_count++;
		complete_run();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		SYS_RST = 1'b1;
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h0;
		TX_EMPTY_IN = 1'b0;
		TX_IDLE_IN = 1'b0;
		CLK_STOPPED = 1'b0;
		repeat (6) @(posedge MCLK);
		SYS_RST <= 1'b0;
		// Reset values, read-only and unmapped places
		rdc(A_ST, 32'h20);
		rdc(A_C1, 32'h0);
		rdc(A_C2, 32'h0);
		rdc(8'h14, 32'h0);
		chk({30'h0, HREADYOUT, HRESP}, 32'h2);
		wr(A_BAUD, 32'h1234);
		rdc(A_BAUD, 32'h1234);
		wr(A_BAUD, 32'h0);
		wr(A_ST, 32'hFF);
		rdc(A_ST, 32'h20);
		// Disabled receiver ignores the line
		u_tx.send(9'h0A5, 8, 1'b1, 1, -1);
		rdc(A_ST, 32'h20);
		wr(A_C2, 32'h3);
		rdc(A_C2, 32'h3);
		irq_base = irq_cnt;
		fork
			u_tx.send(9'h0A5, 8, 1'b1, 1, -1);
			begin
				repeat (60) @(posedge MCLK);
				rdc(A_ST, 32'h0);
			end
		join
		expect_word(32'h21, 32'hA5, 32'h1);
		rdc(A_ST, 32'h20);
		// Three words unread: third dropped, overrun raised
		for (i = 1; i < 4; i++)
			u_tx.send(9'(i * 17), 8, 1'b1, 1, -1);
		chk(irq_cnt - irq_base, 32'h3);
		rdc(A_ST, 32'h23);
		rdc(A_DAT, 32'h11);
		rdc(A_ST, 32'h21);
		rdc(A_DAT, 32'h22);
		rdc(A_ST, 32'h20);
		irq_base = irq_cnt;
		// Low stop bit, then a long break
		u_tx.send(9'h05A, 8, 1'b0, 1, -1);
		expect_word(32'h29, 32'h5A, 32'h1);
		u_tx.send(9'h000, 8, 1'b0, 20, -1);
		expect_word(32'h29, 32'h0, 32'h1);
		rdc(A_ST, 32'h20);
		// Glitch inside a bit
		u_tx.send(9'h0C3, 8, 1'b1, 1, 3);
		expect_word(32'h25, 32'hC3, 32'h1);
		rdc(A_ST, 32'h20);
		// Odd and even parity, good and bad
		for (i = 0; i < 4; i++)
		begin
			wr(A_C1, par_c[i]);
			u_tx.send(par_d[i], 8, 1'b1, 1, -1);
			rdc(A_ST, par_s[i]);
			bus(A_DAT, 1'b0, 32'h0, v);
		end
		// Nine-bit word
		wr(A_C1, 32'h1);
		irq_base = irq_cnt;
		u_tx.send(9'h1A5, 9, 1'b1, 1, -1);
		rdc(A_C1, 32'h9);
		expect_word(32'h21, 32'h1A5, 32'h1);
		// Address detect and the shared receive enable
		wr(A_C1, 32'h0);
		for (i = 0; i < 3; i++)
		begin
			wr(A_C2, ad_c[i]);
			irq_base = irq_cnt;
			u_tx.send(ad_d[i], 8, 1'b1, 1, -1);
			expect_word(32'h21, 32'(ad_d[i]), ad_n[i]);
		end
		// Wake on a falling line while the serial clock is stopped
		wr(A_C2, 32'hB);
		irq_base = irq_cnt;
		@(posedge MCLK);
		CLK_STOPPED <= 1'b1;
		u_tx.hold(1'b1, 2);
		u_tx.hold(1'b0, 4);
		u_tx.hold(1'b1, 4);
		CLK_STOPPED <= 1'b0;
		chk(irq_cnt - irq_base, 32'h1);
		rdc(A_ST, 32'h20);
		// Transmitter conditions, one enabled and one masked
		wr(A_C2, 32'h11);
		irq_base = irq_cnt;
		@(posedge MCLK);
		TX_EMPTY_IN <= 1'b1;
		TX_IDLE_IN <= 1'b1;
		repeat (4) @(posedge MCLK);
		chk(irq_cnt - irq_base, 32'h1);
		rdc(A_ST, 32'hE0);
		complete_run();
	end
endmodule
